// [mmn_regs.vh]
// constants for the move, multiply and negate execute block
// assumes one 250 MHz core clock and four phases per instruction cycle
// Notes on behaviour
// RULE_01: copy file register to working register if d=0, back to file if d=1.
// RULE_02: access bit 0 uses access bank; 1 uses bank select register.
// RULE_03: 8-bit file operand is an offset inside a 256-byte bank.
// RULE_04: reg-to-reg move: word 1100 with 12-bit source, word 1111 with destination.
// RULE_05: reg-to-reg move takes two cycles; no dummy read; write in fourth phase.
// RULE_06: working register may be source or destination; flags untouched.
// RULE_07: software never targets program counter low or stack top bytes.
// RULE_08: opcode 0000 0001 loads literal into bank select register; flags untouched.
// RULE_09: opcode 0000 1110 loads literal into working register; flags untouched.
// RULE_10: opcode 0110 111a stores working register into file register.
// RULE_11: opcode 0000 1101 multiplies working register by literal into product pair.
// RULE_12: multiplies never change status flags, even on zero product.
// RULE_13: opcode 0000 001a multiplies working register by file register.
// RULE_14: negate file register in two's complement; update all five status flags.
// RULE_15: file copy sets zero and negative flags from the moved byte.
// RULE_16: single-cycle ops decode, read, process, write in phases one to four.
`ifndef MMN_REGS_VH
`define MMN_REGS_VH

// opcode fields
`define MMN_OP_COPY_FILE  6'h14
`define MMN_OP_COPY_REG1  4'hC
`define MMN_OP_COPY_REG2  4'hF
`define MMN_OP_LOAD_BANK  8'h01
`define MMN_OP_LOAD_WORK  8'h0E
`define MMN_OP_MUL_LIT    8'h0D
`define MMN_OP_MUL_FILE   7'h01
`define MMN_OP_STORE_WORK 7'h37
`define MMN_OP_NEGATE     7'h36

// data space map
`define MMN_WORK_ADDR     12'hFE8
`define MMN_ACC_SPLIT     8'h80
`define MMN_ACC_HI_BANK   4'hF
`define MMN_ACC_LO_BANK   4'h0

// status bit positions
`define MMN_ST_C   0
`define MMN_ST_HC  1
`define MMN_ST_Z   2
`define MMN_ST_SW  3
`define MMN_ST_N   4

// register offsets
`define MMN_REG_WORK   8'h00
`define MMN_REG_BANK   8'h04
`define MMN_REG_PRD_LO 8'h08
`define MMN_REG_PRD_HI 8'h0C
`define MMN_REG_STATUS 8'h10
`define MMN_REG_CTRL   8'h14
`define MMN_REG_STATE  8'h18

`endif

// [mmn_exec.v]
// move, multiply and negate group: decode and execute
// assumes instruction words and memory read data are synchronous
`timescale 1ns/1ps
`include "mmn_regs.vh"

module mmn_exec (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_reset,
    // register port
    input  wire [7:0]  i_reg_addr,
    input  wire [31:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output wire [31:0] o_reg_rdata,
    // instruction stream
    input  wire [15:0] i_instr,
    output wire [3:0]  o_phase,
    // data memory
    output wire [11:0] o_mem_addr,
    output wire        o_mem_rd,
    output wire        o_mem_wr,
    output wire [7:0]  o_mem_wdata,
    input  wire [7:0]  i_mem_rdata
);

    // phase codes
    localparam [3:0] PH_DEC  = 4'h1;
    localparam [3:0] PH_READ = 4'h2;
    localparam [3:0] PH_PROC = 4'h4;
    localparam [3:0] PH_WRITE = 4'h8;

    // instruction kinds
    localparam [8:0] K_NONE  = 9'h000;
    localparam [8:0] K_COPYF = 9'h001;
    localparam [8:0] K_MVF1  = 9'h002;
    localparam [8:0] K_MVF2  = 9'h004;
    localparam [8:0] K_LDB   = 9'h008;
    localparam [8:0] K_LDW   = 9'h010;
    localparam [8:0] K_STW   = 9'h020;
    localparam [8:0] K_MULL  = 9'h040;
    localparam [8:0] K_MULF  = 9'h080;
    localparam [8:0] K_NEG   = 9'h100;

    reg  [3:0]  ph_r;
    reg  [8:0]  kind_r;
    reg  [8:0]  kind_nxt;
    reg  [7:0]  work_r;
    reg  [7:0]  bank_r;
    reg  [7:0]  prod_lo_r;
    reg  [7:0]  prod_hi_r;
    reg  [4:0]  status_r;
    reg         run_r;
    reg         pend_r;
    reg  [7:0]  lit_r;
    reg         dest_r;
    reg         is_work_r;
    reg  [7:0]  opnd_r;
    reg  [7:0]  move_r;
    reg  [11:0] addr_r;
    reg  [11:0] addr_nxt;
    reg         need_rd;
    reg         rd_r;
    reg         wr_r;
    reg  [7:0]  wdata_r;
    reg  [31:0] rdata_r;
    reg  [31:0] rdata_nxt;
    reg  [11:0] bank_addr;

    wire        adv;
    wire [7:0]  op_val;
    wire [7:0]  neg_now;
    wire [7:0]  neg_q;
    wire [15:0] prod_lit;
    wire [15:0] prod_file;
    wire [4:0]  neg_flags;

    assign o_phase     = ph_r;
    assign o_mem_addr  = addr_r;
    assign o_mem_rd    = rd_r;
    assign o_mem_wr    = wr_r;
    assign o_mem_wdata = wdata_r;
    assign o_reg_rdata = rdata_r;

    // hold in decode phase while stopped
    assign adv = ~(ph_r[0] & ~run_r);

    // operand source: working register or memory
    // RULE_06: working register source
    assign op_val = is_work_r ? work_r : i_mem_rdata;

    // RULE_14: inverted plus one
    assign neg_now = ~op_val + 8'h01;
    assign neg_q   = ~opnd_r + 8'h01;

    // RULE_11: unsigned literal product
    assign prod_lit  = {8'h00, work_r} * {8'h00, lit_r};
    // RULE_13: unsigned file product
    assign prod_file = {8'h00, work_r} * {8'h00, opnd_r};

    // RULE_14: negate flags
    assign neg_flags[`MMN_ST_C]  = (opnd_r == 8'h00);
    assign neg_flags[`MMN_ST_HC] = (opnd_r[3:0] == 4'h0);
    assign neg_flags[`MMN_ST_Z]  = (neg_q == 8'h00);
    assign neg_flags[`MMN_ST_SW] = (opnd_r == 8'h80);
    assign neg_flags[`MMN_ST_N]  = neg_q[7];

    // banked address of the file operand
    always @* begin
        // RULE_02: access bank or bank select
        if (i_instr[8]) begin
            // RULE_03: offset in 256-byte bank
            bank_addr = {bank_r[3:0], i_instr[7:0]};
        end else if (i_instr[7:0] < `MMN_ACC_SPLIT) begin
            bank_addr = {`MMN_ACC_LO_BANK, i_instr[7:0]};
        end else begin
            bank_addr = {`MMN_ACC_HI_BANK, i_instr[7:0]};
        end
    end

    // instruction decode
    always @* begin
        kind_nxt = K_NONE;
        addr_nxt = bank_addr;
        need_rd  = 1'b0;
        // RULE_04: two-word move decode
        if (pend_r && i_instr[15:12] == `MMN_OP_COPY_REG2) begin
            kind_nxt = K_MVF2;
            addr_nxt = i_instr[11:0];
        end else if (i_instr[15:12] == `MMN_OP_COPY_REG1) begin
            kind_nxt = K_MVF1;
            addr_nxt = i_instr[11:0];
            need_rd  = 1'b1;
        end else if (i_instr[15:10] == `MMN_OP_COPY_FILE) begin
            kind_nxt = K_COPYF;
            need_rd  = 1'b1;
        end else if (i_instr[15:8] == `MMN_OP_LOAD_BANK) begin
            // RULE_08: bank literal
            kind_nxt = K_LDB;
        end else if (i_instr[15:8] == `MMN_OP_LOAD_WORK) begin
            // RULE_09: work literal
            kind_nxt = K_LDW;
        end else if (i_instr[15:8] == `MMN_OP_MUL_LIT) begin
            kind_nxt = K_MULL;
        end else if (i_instr[15:9] == `MMN_OP_MUL_FILE) begin
            kind_nxt = K_MULF;
            need_rd  = 1'b1;
        end else if (i_instr[15:9] == `MMN_OP_STORE_WORK) begin
            // RULE_10: store working register
            kind_nxt = K_STW;
        end else if (i_instr[15:9] == `MMN_OP_NEGATE) begin
            // RULE_14: negate decode
            kind_nxt = K_NEG;
            need_rd  = 1'b1;
        end
    end

    // register port read mux
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (i_reg_rd) begin
            case (i_reg_addr)
                `MMN_REG_WORK:   rdata_nxt[7:0] = work_r;
                `MMN_REG_BANK:   rdata_nxt[7:0] = bank_r;
                `MMN_REG_PRD_LO: rdata_nxt[7:0] = prod_lo_r;
                `MMN_REG_PRD_HI: rdata_nxt[7:0] = prod_hi_r;
                `MMN_REG_STATUS: rdata_nxt[4:0] = status_r;
                `MMN_REG_CTRL:   rdata_nxt[0]   = run_r;
                `MMN_REG_STATE:  rdata_nxt[7:0] = {ph_r, 3'h0, pend_r};
                default:         rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // phase sequencer, execute and register port
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            ph_r      <= PH_DEC;
            kind_r    <= K_NONE;
            work_r    <= 8'h00;
            bank_r    <= 8'h00;
            prod_lo_r <= 8'h00;
            prod_hi_r <= 8'h00;
            status_r  <= 5'h00;
            run_r     <= 1'b0;
            pend_r    <= 1'b0;
            lit_r     <= 8'h00;
            dest_r    <= 1'b0;
            is_work_r <= 1'b0;
            opnd_r    <= 8'h00;
            move_r    <= 8'h00;
            addr_r    <= 12'h000;
            rd_r      <= 1'b0;
            wr_r      <= 1'b0;
            wdata_r   <= 8'h00;
            rdata_r   <= 32'h0000_0000;
        end else begin
            rd_r    <= 1'b0;
            wr_r    <= 1'b0;
            rdata_r <= rdata_nxt;
            // software writes; execute writes below win
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `MMN_REG_WORK:   work_r   <= i_reg_wdata[7:0];
                    `MMN_REG_BANK:   bank_r   <= i_reg_wdata[7:0];
                    `MMN_REG_STATUS: status_r <= i_reg_wdata[4:0];
                    `MMN_REG_CTRL:   run_r    <= i_reg_wdata[0];
                    default:         run_r    <= run_r;
                endcase
            end
            if (adv) begin
                ph_r <= {ph_r[2:0], ph_r[3]};
            end
            // RULE_16: four-phase cycle
            case (ph_r)
                PH_DEC: begin
                    if (run_r) begin
                        kind_r    <= kind_nxt;
                        addr_r    <= addr_nxt;
                        lit_r     <= i_instr[7:0];
                        dest_r    <= i_instr[9];
                        is_work_r <= (addr_nxt == `MMN_WORK_ADDR);
                        pend_r    <= (kind_nxt == K_MVF1);
                        // RULE_05: no dummy read on second word
                        rd_r      <= need_rd && (addr_nxt != `MMN_WORK_ADDR);
                    end
                end
                PH_READ: begin
                    kind_r <= kind_r;
                end
                PH_PROC: begin
                    opnd_r <= op_val;
                    case (kind_r)
                        K_COPYF: begin
                            // RULE_01: write back when d is 1
                            wr_r    <= dest_r && !is_work_r;
                            wdata_r <= op_val;
                        end
                        K_MVF1: begin
                            // RULE_05: source read in first cycle
                            move_r <= op_val;
                        end
                        K_MVF2: begin
                            // RULE_05: destination written last phase
                            wr_r    <= !is_work_r;
                            wdata_r <= move_r;
                        end
                        K_STW: begin
                            wr_r    <= !is_work_r;
                            wdata_r <= work_r;
                        end
                        K_NEG: begin
                            // RULE_14: result back to file
                            wr_r    <= !is_work_r;
                            wdata_r <= neg_now;
                        end
                        default: wr_r <= 1'b0;
                    endcase
                end
                PH_WRITE: begin
                    case (kind_r)
                        K_COPYF: begin
                            // RULE_01: copy to working register
                            if (!dest_r || is_work_r) begin
                                work_r <= opnd_r;
                            end
                            // RULE_15: zero and negative flags
                            status_r[`MMN_ST_Z] <= (opnd_r == 8'h00);
                            status_r[`MMN_ST_N] <= opnd_r[7];
                        end
                        K_MVF2: begin
                            // RULE_06: working register destination
                            if (is_work_r) begin
                                work_r <= move_r;
                            end
                        end
                        K_LDB: begin
                            // RULE_08: load bank select
                            bank_r <= lit_r;
                        end
                        K_LDW: begin
                            // RULE_09: load working register
                            work_r <= lit_r;
                        end
                        K_MULL: begin
                            // RULE_12: flags left alone
                            prod_hi_r <= prod_lit[15:8];
                            prod_lo_r <= prod_lit[7:0];
                        end
                        K_MULF: begin
                            // RULE_13: product pair update
                            prod_hi_r <= prod_file[15:8];
                            prod_lo_r <= prod_file[7:0];
                        end
                        K_NEG: begin
                            if (is_work_r) begin
                                work_r <= neg_q;
                            end
                            // RULE_14: five flags updated
                            status_r <= neg_flags;
                        end
                        default: kind_r <= kind_r;
                    endcase
                end
                default: ph_r <= PH_DEC;
            endcase
        end
    end

endmodule // mmn_exec

// [mmn_exec_sva.sv]
// checker for the move, multiply and negate execute block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module mmn_exec_sva (
    // clock and reset
    input wire        i_sys_clk,
    input wire        i_reset,
    // instruction and memory side
    input wire [15:0] i_instr,
    input wire [3:0]  o_phase,
    input wire [11:0] o_mem_addr,
    input wire        o_mem_rd,
    input wire        o_mem_wr,
    input wire [7:0]  o_mem_wdata,
    input wire [7:0]  i_mem_rdata
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    a_phase_order: assert property (o_phase == 4'h2 |=> o_phase == 4'h4 ##1 o_phase == 4'h8 ##1 o_phase == 4'h1)
        else $error("phase order broken");
    a_read_phase: assert property (o_mem_rd |-> o_phase == 4'h2)
        else $error("memory read outside read phase");
    a_write_phase: assert property (o_mem_wr |-> o_phase == 4'h8)
        else $error("memory write outside write phase");
    a_addr_hold: assert property (o_phase == 4'h2 |=> $stable(o_mem_addr) [*2])
        else $error("address moved inside instruction");
    a_copy_reads: assert property (o_phase == 4'h1 && i_instr[15:10] == 6'h14 ##1 o_phase == 4'h2 && o_mem_addr != 12'hFE8
        |-> o_mem_rd)
        else $error("file copy did not read");
    a_store_writes: assert property (o_phase == 4'h1 && i_instr[15:9] == 7'h37 ##1 o_phase == 4'h2 && o_mem_addr != 12'hFE8
        |-> !o_mem_rd ##2 o_mem_wr)
        else $error("store access pattern wrong");
    a_negate_value: assert property (o_phase == 4'h1 && i_instr[15:9] == 7'h36 ##1 o_phase == 4'h2 && o_mem_addr != 12'hFE8
        |-> ##2 o_mem_wr && o_mem_wdata == 8'h00 - $past(i_mem_rdata))
        else $error("negate result wrong");
    a_mul_quiet: assert property (o_phase == 4'h1 && i_instr[15:8] == 8'h0D ##1 o_phase == 4'h2
        |-> (!o_mem_rd && !o_mem_wr) [*3])
        else $error("literal multiply touched memory");
    a_move_no_dummy: assert property (o_phase == 4'h1 && i_instr[15:12] == 4'hC ##1 o_phase == 4'h2
        |-> ##4 o_phase == 4'h2 && !o_mem_rd)
        else $error("second move word read memory");
endmodule // mmn_exec_sva

bind mmn_exec mmn_exec_sva mmn_exec_sva_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_instr(i_instr),
    .o_phase(o_phase), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata));

// [mmn_exec_tb.sv]
// self-checking bench for the move, multiply and negate execute block
// assumes a behavioural data memory answering in the process phase
`timescale 1ns/1ps
module mmn_exec_tb;
    logic        i_sys_clk   = 1'b0;
    logic        i_reset     = 1'b1;
    logic [7:0]  i_reg_addr  = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic        i_reg_wr    = 1'b0;
    logic        i_reg_rd    = 1'b0;
    logic [15:0] i_instr     = 16'h0000;
    logic [7:0]  i_mem_rdata = 8'h00;
    wire  [31:0] o_reg_rdata;
    wire  [3:0]  o_phase;
    wire  [11:0] o_mem_addr;
    wire         o_mem_rd;
    wire         o_mem_wr;
    wire  [7:0]  o_mem_wdata;
    logic [7:0]  mem [0:4095];
    int          n_fail      = 0;
    int          checks_done = 0;

    always #2 i_sys_clk = ~i_sys_clk;

    mmn_exec mmn_exec_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_instr(i_instr), .o_phase(o_phase), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
        .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata));

    // data memory, scrambled read bus when idle
    always @(posedge i_sys_clk) begin
        i_mem_rdata <= o_mem_rd ? mem[o_mem_addr] : ~i_mem_rdata;
        if (o_mem_wr)
            mem[o_mem_addr] <= o_mem_wdata;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_reg_rdata, exp);
        @(posedge i_sys_clk);
    endtask

    // one or two words, then the bus goes back to a no-op
    task automatic exec(input logic [15:0] w1, input logic [15:0] w2 = 16'h0000);
        int n;
        n = 0;
        i_instr <= w1;
        @(negedge i_sys_clk);
        while (o_phase !== 4'h1 && n < 8) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 8) begin
            n_fail++;
            end_sim();
        end
        @(posedge i_sys_clk);
        if (w2 !== 16'h0000) begin
            i_instr <= w2;
            repeat (4) @(posedge i_sys_clk);
        end
        repeat (2) @(posedge i_sys_clk);
        i_instr <= 16'h0000;
        @(posedge i_sys_clk);
    endtask

    task automatic t_reset();
        reg_chk(8'h00, 32'h0);
        reg_chk(8'h04, 32'h0);
        reg_chk(8'h10, 32'h0);
        reg_chk(8'h14, 32'h0);
        reg_chk(8'h18, 32'h10);
        reg_wr(8'h08, 32'hFF);
        reg_chk(8'h08, 32'h0);
        reg_chk(8'h1C, 32'h0);
        reg_wr(8'h14, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_literals();
        reg_wr(8'h10, 32'h1F);
        exec(16'h0E5A);
        exec(16'h0105);
        reg_chk(8'h00, 32'h5A);
        reg_chk(8'h04, 32'h05);
        reg_chk(8'h10, 32'h1F);
        $display("test literals done");
    endtask

    task automatic t_copy();
        reg_wr(8'h10, 32'h0);
        mem[12'h010] = 8'h00;
        mem[12'h5A5] = 8'h80;
        mem[12'hF90] = 8'h3C;
        exec(16'h5010);
        reg_chk(8'h00, 32'h00);
        reg_chk(8'h10, 32'h04);
        exec(16'h51A5);
        reg_chk(8'h00, 32'h80);
        reg_chk(8'h10, 32'h10);
        exec(16'h5290);
        reg_chk(8'h00, 32'h80);
        reg_chk(8'h10, 32'h00);
        $display("test copy done");
    endtask

    task automatic t_store();
        exec(16'h0E4F);
        exec(16'h6F22);
        exec(16'h6E90);
        reg_chk(8'h10, 32'h00);
        chk({24'h0, mem[12'h522]}, 32'h4F);
        chk({24'h0, mem[12'hF90]}, 32'h4F);
        $display("test store done");
    endtask

    task automatic t_mul();
        exec(16'h0EE2);
        exec(16'h0DC4);
        reg_chk(8'h08, 32'h08);
        reg_chk(8'h0C, 32'hAD);
        reg_chk(8'h00, 32'hE2);
        reg_wr(8'h10, 32'h1F);
        exec(16'h0D00);
        reg_chk(8'h0C, 32'h00);
        reg_chk(8'h10, 32'h1F);
        mem[12'h033] = 8'hB5;
        exec(16'h0EC4);
        exec(16'h0233);
        reg_chk(8'h08, 32'h94);
        reg_chk(8'h0C, 32'h8A);
        $display("test multiply done");
    endtask

    task automatic neg_one(input logic [7:0] v, input logic [7:0] r, input logic [31:0] st);
        mem[12'h540] = v;
        exec(16'h6D40);
        reg_chk(8'h10, st);
        chk({24'h0, mem[12'h540]}, {24'h0, r});
    endtask

    task automatic t_negate();
        neg_one(8'h3A, 8'hC6, 32'h10);
        neg_one(8'h80, 8'h80, 32'h1A);
        neg_one(8'h00, 8'h00, 32'h07);
        $display("test negate done");
    endtask

    task automatic t_move();
        mem[12'h123] = 8'h33;
        mem[12'h300] = 8'h5C;
        exec(16'hC123, 16'hF456);
        reg_chk(8'h10, 32'h07);
        chk({24'h0, mem[12'h456]}, 32'h33);
        exec(16'hC123, 16'hFFE8);
        reg_chk(8'h00, 32'h33);
        exec(16'h0E77);
        exec(16'hCFE8, 16'hF200);
        reg_chk(8'h10, 32'h07);
        chk({24'h0, mem[12'h200]}, 32'h77);
        exec(16'hF300);
        reg_chk(8'h18, 32'h10);
        chk({24'h0, mem[12'h300]}, 32'h5C);
        $display("test move done");
    endtask

    initial begin
        for (int k = 0; k < 4096; k++)
            mem[k] = k[7:0] ^ 8'hA5;
        repeat (5) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        @(posedge i_sys_clk);
        t_reset();
        t_literals();
        t_copy();
        t_store();
        t_mul();
        t_negate();
        t_move();
        end_sim();
    end
endmodule // mmn_exec_tb
